/* logic/lsd_defs.vh */
`ifndef LSD_DEFS_VH
`define LSD_DEFS_VH

// Terminal and slot geometry.
`define LSD_TERMS        26
`define LSD_PAIRS        13
`define LSD_COMS         4
`define LSD_SLOTS        104
`define LSD_LAST_SLOT    7'h67
`define LSD_ENTRY_W      11

// Slot entry field positions: valid, high digit, low nibble, bit index.
`define LSD_ENT_VALID    10
`define LSD_ENT_HI_MSB   9
`define LSD_ENT_HI_LSB   6
`define LSD_ENT_LO_MSB   5
`define LSD_ENT_LO_LSB   2
`define LSD_ENT_BIT_MSB  1
`define LSD_ENT_BIT_LSB  0

// Display memory area high digits and word count.
`define LSD_HI_FIRST     4'h9
`define LSD_HI_LAST      4'ha
`define LSD_MEM_WORDS    32
`define LSD_MEM_AW       5

// Register byte offsets.
`define LSD_OFF_MEM_LAST 12'h07c
`define LSD_OFF_CTRL     12'h100
`define LSD_OFF_DCLEVEL  12'h104
`define LSD_OFF_MODE     12'h108
`define LSD_OFF_OPEN     12'h10c

// Control register fields and reset value.
`define LSD_CTRL_SHOW    0
`define LSD_CTRL_RST     1'h1

// AXI responses.
`define LSD_RESP_OKAY    2'h0
`define LSD_RESP_SLVERR  2'h2

`endif

/* logic/lsd_mem.v */
`default_nettype none

// Display memory, one write port and two read ports, read data registered.
module lsd_mem (
  input  wire       CLK,
  input  wire       NRST,
  input  wire       we,
  input  wire [4:0] waddr,
  input  wire [3:0] wdata,
  input  wire [4:0] raddr_a,
  output reg  [3:0] rdata_a,
  input  wire [4:0] raddr_b,
  output reg  [3:0] rdata_b
);

  reg [3:0] mem [0:31];

  always @(posedge CLK) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_a <= 4'h0;
      rdata_b <= 4'h0;
    end else begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end

endmodule

`default_nettype wire

/* logic/lsd_decoder.v */
// Contract
// - Each terminal pair is set, as a pair, to panel drive or DC output.
// - DC pairs are further set complementary or open drain, P or N channel.
// - Any memory bit in the display area may feed any terminal slot.
// - Each memory bit drives at most one terminal slot; SLOT_MAP is not checked, so a bit named twice drives both slots.
// - A slot entry holds high digit, low nibble 0-F and bit 0-3.
// - Panel segment is shown while its bit is 1, blank while 0.
// - DC terminal is high while its bit is 1, low while 0.
// - In DC mode only the first backplane slot controls the terminal.
// - Each terminal multiplexes four backplane slots.
// - Assignable memory spans 90H to AFH in this variant.
// - Evaluation build drives DC complementary even if open drain chosen.
`include "lsd_defs.vh"
`default_nettype none

module lsd_decoder #(
  parameter [1143:0] SLOT_MAP   = lsd_default_map(0),
  parameter [12:0]   PAIR_DC    = 13'h0000,
  parameter [12:0]   PAIR_OPEN  = 13'h0000,
  parameter          OPEN_NCH   = 0,
  parameter          EVAL_BUILD = 1
) (
  input  wire          CLK,
  input  wire          NRST,
  input  wire [11:0]   S_AXI_AWADDR,
  input  wire          S_AXI_AWVALID,
  output wire          S_AXI_AWREADY,
  input  wire [31:0]   S_AXI_WDATA,
  input  wire [3:0]    S_AXI_WSTRB,
  input  wire          S_AXI_WVALID,
  output wire          S_AXI_WREADY,
  output reg  [1:0]    S_AXI_BRESP,
  output reg           S_AXI_BVALID,
  input  wire          S_AXI_BREADY,
  input  wire [11:0]   S_AXI_ARADDR,
  input  wire          S_AXI_ARVALID,
  output wire          S_AXI_ARREADY,
  output reg  [31:0]   S_AXI_RDATA,
  output reg  [1:0]    S_AXI_RRESP,
  output reg           S_AXI_RVALID,
  input  wire          S_AXI_RREADY,
  output reg  [103:0]  PANEL_DRIVE_TERMINAL,
  output reg  [25:0]   DC_OUT,
  output reg  [25:0]   DC_OE_N
);

  // Slot i takes bit i%4 of nibble i/4, starting at 90H, so no bit is
  // used twice; a real build overrides the whole map.
  function [1143:0] lsd_default_map;
    input integer dummy;
    integer i;
    integer n;
    begin
      lsd_default_map = {1144{1'b0}};
      for (i = 0; i < `LSD_SLOTS; i = i + 1) begin
        n = i / 4;
        lsd_default_map[i*11 +: 11] = {1'b1,
          (n < 16) ? `LSD_HI_FIRST : `LSD_HI_LAST,
          n[3:0], i[1:0]};
      end
    end
  endfunction

  localparam [3:0] RD_IDLE = 4'h1;
  localparam [3:0] RD_WAIT = 4'h2;
  localparam [3:0] RD_LOAD = 4'h4;
  localparam [3:0] RD_RESP = 4'h8;

  reg         show_r;
  reg         aw_have_r;
  reg         w_have_r;
  reg  [11:0] aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg  [3:0]  rd_state_r;
  reg  [11:0] ar_addr_r;
  reg  [6:0]  scan_r;
  reg  [6:0]  scan_d_r;
  reg         ok_d_r;
  reg  [1:0]  bit_d_r;
  reg  [103:0] slot_r;

  wire [10:0] entry;
  wire [3:0]  ent_hi;
  wire        ent_ok;
  wire [4:0]  scan_addr;
  wire [3:0]  scan_rdata;
  wire [3:0]  bus_rdata;
  wire        wr_go;
  wire        wr_mem;
  wire        wr_ctrl;
  wire        wr_hit;
  wire        rd_mem;
  reg  [31:0] rd_word;
  reg         rd_hit;
  wire [25:0] term_dc;
  wire [25:0] term_open;

  // Slot entry decode.
  assign entry     = SLOT_MAP[scan_r*11 +: 11];
  assign ent_hi    = entry[`LSD_ENT_HI_MSB:`LSD_ENT_HI_LSB];
  // Entries outside the display area, or marked unused, read as zero.
  assign ent_ok    = entry[`LSD_ENT_VALID] &&
                     (ent_hi == `LSD_HI_FIRST ||
                      ent_hi == `LSD_HI_LAST);
  assign scan_addr = {ent_hi == `LSD_HI_LAST,
                      entry[`LSD_ENT_LO_MSB:`LSD_ENT_LO_LSB]};

  // AXI write side.
  assign S_AXI_AWREADY = !aw_have_r && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_have_r && !S_AXI_BVALID;
  assign wr_go   = aw_have_r && w_have_r && !S_AXI_BVALID;
  assign wr_mem  = wr_go && aw_addr_r <= `LSD_OFF_MEM_LAST &&
                   aw_addr_r[1:0] == 2'h0;
  assign wr_ctrl = wr_go && aw_addr_r == `LSD_OFF_CTRL;
  assign wr_hit  = aw_addr_r <= `LSD_OFF_MEM_LAST ||
                   aw_addr_r == `LSD_OFF_CTRL ||
                   aw_addr_r == `LSD_OFF_DCLEVEL ||
                   aw_addr_r == `LSD_OFF_MODE ||
                   aw_addr_r == `LSD_OFF_OPEN;

  // A beat is held until its partner arrives, so AW and W may come in
  // either order; a pending response blocks both channels.
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      aw_addr_r    <= 12'h000;
      w_data_r     <= 32'h00000000;
      w_strb_r     <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `LSD_RESP_OKAY;
      show_r       <= `LSD_CTRL_RST;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_hit && aw_addr_r[1:0] == 2'h0 ?
                        `LSD_RESP_OKAY : `LSD_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (wr_ctrl && w_strb_r[0]) begin
        show_r <= w_data_r[`LSD_CTRL_SHOW];
      end
    end
  end

  // Port a serves the scanner and port b the bus, so register reads
  // never stall the display refresh.
  lsd_mem u_mem (
    .CLK     (CLK),
    .NRST    (NRST),
    .we      (wr_mem && w_strb_r[0]),
    .waddr   (aw_addr_r[6:2]),
    .wdata   (w_data_r[3:0]),
    .raddr_a (scan_addr),
    .rdata_a (scan_rdata),
    .raddr_b (ar_addr_r[6:2]),
    .rdata_b (bus_rdata)
  );

  // AXI read side. The address is latched at the handshake and the memory
  // word of that address is registered one edge later, so the answer is
  // loaded two edges after the handshake.
  assign S_AXI_ARREADY = rd_state_r == RD_IDLE;
  assign rd_mem = ar_addr_r <= `LSD_OFF_MEM_LAST;

  always @* begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    if (rd_mem) begin
      rd_word = {28'h0000000, bus_rdata};
    end else if (ar_addr_r == `LSD_OFF_CTRL) begin
      rd_word = {31'h00000000, show_r};
    end else if (ar_addr_r == `LSD_OFF_DCLEVEL) begin
      rd_word = {6'h00, DC_OUT};
    end else if (ar_addr_r == `LSD_OFF_MODE) begin
      rd_word = {19'h00000, PAIR_DC};
    end else if (ar_addr_r == `LSD_OFF_OPEN) begin
      rd_word = {19'h00000, PAIR_OPEN};
    end else begin
      rd_hit = 1'b0;
    end
    if (ar_addr_r[1:0] != 2'h0) begin
      rd_hit  = 1'b0;
      rd_word = 32'h00000000;
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rd_state_r   <= RD_IDLE;
      ar_addr_r    <= 12'h000;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h00000000;
      S_AXI_RRESP  <= `LSD_RESP_OKAY;
    end else begin
      case (rd_state_r)
        RD_IDLE: begin
          if (S_AXI_ARVALID) begin
            ar_addr_r  <= S_AXI_ARADDR;
            rd_state_r <= RD_WAIT;
          end
        end
        RD_WAIT: begin
          // Port b still shows the word of the previous address here.
          rd_state_r <= RD_LOAD;
        end
        RD_LOAD: begin
          S_AXI_RVALID <= 1'b1;
          S_AXI_RDATA  <= rd_word;
          S_AXI_RRESP  <= rd_hit ? `LSD_RESP_OKAY : `LSD_RESP_SLVERR;
          rd_state_r   <= RD_RESP;
        end
        RD_RESP: begin
          if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            rd_state_r   <= RD_IDLE;
          end
        end
        default: begin
          S_AXI_RVALID <= 1'b0;
          rd_state_r   <= RD_IDLE;
        end
      endcase
    end
  end

  // Slot scanner: one slot per cycle, a full refresh every 104 cycles.
  // Scanning through one read port keeps the memory small at the cost of
  // a refresh latency of about 10.4 us, far below any visible rate.
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      scan_r   <= 7'h00;
      scan_d_r <= 7'h00;
      ok_d_r   <= 1'b0;
      bit_d_r  <= 2'h0;
      slot_r   <= {104{1'b0}};
    end else begin
      scan_r   <= scan_r == `LSD_LAST_SLOT ? 7'h00 : scan_r + 7'h01;
      scan_d_r <= scan_r;
      ok_d_r   <= ent_ok;
      bit_d_r  <= entry[`LSD_ENT_BIT_MSB:`LSD_ENT_BIT_LSB];
      // Each slot picks exactly one bit, but SLOT_MAP is not checked, so a bit named twice lands in both slots.
      slot_r[scan_d_r] <= ok_d_r & scan_rdata[bit_d_r];
    end
  end

  // Per terminal output stage; a DC pair always shows a blank segment
  // word so the panel never sees a level it cannot use.
  genvar t;
  generate
    for (t = 0; t < `LSD_TERMS; t = t + 1) begin : g_term
      assign term_dc[t]   = PAIR_DC[t/2];
      assign term_open[t] = PAIR_OPEN[t/2] && EVAL_BUILD == 0;

      always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          PANEL_DRIVE_TERMINAL[t*4 +: 4] <= 4'h0;
          DC_OUT[t]  <= 1'b0;
          DC_OE_N[t] <= 1'b1;
        end else if (term_dc[t]) begin
          PANEL_DRIVE_TERMINAL[t*4 +: 4] <= 4'h0;
          DC_OUT[t] <= slot_r[t*4];
          // An open-drain stage drives only toward its own rail and
          // releases the pin otherwise, leaving the level to the load.
          if (!term_open[t]) begin
            DC_OE_N[t] <= 1'b0;
          end else if (OPEN_NCH != 0) begin
            DC_OE_N[t] <= slot_r[t*4];
          end else begin
            DC_OE_N[t] <= !slot_r[t*4];
          end
        end else begin
          // Four backplane slots multiplex onto one terminal.
          PANEL_DRIVE_TERMINAL[t*4 +: 4] <=
            slot_r[t*4 +: 4] & {4{show_r}};
          DC_OUT[t]  <= 1'b0;
          DC_OE_N[t] <= 1'b1;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* verification/lsd_panel.sv */
`default_nettype none
module lsd_panel (
  input  wire logic [103:0] drive,
  input  wire logic [25:0]  dc_out,
  input  wire logic [25:0]  dc_oe_n,
  output logic      [25:0]  pin,
  output logic      [25:0]  lit
);
  timeunit 1ns;
  timeprecision 1ns;
  // The electrode load pulls an undriven terminal low, so a stuck
  // enable shows as a wrong level rather than a lucky match.
  always_comb begin
    for (int t = 0; t < 26; t++) begin
      pin[t] = !dc_oe_n[t] & dc_out[t];
      // A terminal glows when any of its four backplane slots is shown.
      lit[t] = |drive[t*4+:4];
    end
  end
endmodule
`default_nettype wire

/* verification/lsd_chk_asserts.sv */
`include "lsd_defs.vh"
`default_nettype none
module lsd_chk #(
  parameter [12:0] PAIR_DC   = 13'h0000,
  parameter [12:0] PAIR_OPEN = 13'h0000
) (
  input wire logic         CLK,
  input wire logic         NRST,
  input wire logic         S_AXI_AWVALID,
  input wire logic         S_AXI_AWREADY,
  input wire logic         S_AXI_WVALID,
  input wire logic         S_AXI_WREADY,
  input wire logic [1:0]   S_AXI_BRESP,
  input wire logic         S_AXI_BVALID,
  input wire logic         S_AXI_BREADY,
  input wire logic [11:0]  S_AXI_ARADDR,
  input wire logic         S_AXI_ARVALID,
  input wire logic         S_AXI_ARREADY,
  input wire logic [31:0]  S_AXI_RDATA,
  input wire logic         S_AXI_RVALID,
  input wire logic         S_AXI_RREADY,
  input wire logic [103:0] PANEL_DRIVE_TERMINAL,
  input wire logic [25:0]  DC_OUT,
  input wire logic [25:0]  DC_OE_N
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [25:0]  dcm;
  logic [25:0]  odm;
  logic [103:0] dcs;
  logic [11:0]  ar_r;
  always_comb begin
    for (int t = 0; t < 26; t++) begin
      dcm[t] = PAIR_DC[t/2];
      odm[t] = PAIR_OPEN[t/2] & PAIR_DC[t/2];
      dcs[t*4+:4] = {4{PAIR_DC[t/2]}};
    end
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) ar_r <= 12'h000;
    else if (S_AXI_ARVALID && S_AXI_ARREADY) ar_r <= S_AXI_ARADDR;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_wr;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  AST_OE_PAIRS: assert property (
    $past(NRST, 3) |-> DC_OE_N == ~dcm) else $error("dc enable map wrong");
  AST_OPEN_EVAL: assert property (
    $past(NRST, 3) |-> (DC_OE_N & odm) == 26'h0)
    else $error("open drain pair not driven");
  AST_DC_PANEL_LOW: assert property (
    (DC_OUT & ~dcm) == 26'h0) else $error("dc level on panel terminal");
  AST_SEG_DC_BLANK: assert property (
    (PANEL_DRIVE_TERMINAL & dcs) == 104'h0)
    else $error("segment lit on dc terminal");
  AST_PAIR_REG: assert property (
    S_AXI_RVALID && ar_r == `LSD_OFF_MODE |-> S_AXI_RDATA == {19'h0, PAIR_DC})
    else $error("pair mode register wrong");
  AST_B_ANSWER: assert property (s_wr |-> ##[1:2] S_AXI_BVALID)
    else $error("write response late");
  AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
  AST_R_ANSWER: assert property (s_rd |-> ##[1:3] S_AXI_RVALID)
    else $error("read response late");
  AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata dropped");
endmodule
bind lsd_decoder lsd_chk #(.PAIR_DC(PAIR_DC), .PAIR_OPEN(PAIR_OPEN)) lsd_chk_i (
  .CLK(CLK), .NRST(NRST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .PANEL_DRIVE_TERMINAL(PANEL_DRIVE_TERMINAL),
  .DC_OUT(DC_OUT), .DC_OE_N(DC_OE_N));
`default_nettype wire

/* verification/test_lcd_segment_output_decoder.sv */
`include "lsd_defs.vh"
`default_nettype none
module test_lcd_segment_output_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [12:0] PDC = 13'h0401;
  localparam [12:0] POD = 13'h0001;
  logic         clk_v = 1'b0;
  logic         nrst = 1'b0;
  logic [11:0]  ad = 12'h000;
  logic [31:0]  wd = 32'h0;
  logic         awv = 1'b0;
  logic         wv = 1'b0;
  logic         arv = 1'b0;
  logic         br = 1'b0;
  logic         rr = 1'b0;
  logic         awr, wrd, bv, arr, rv;
  logic [1:0]   bres, rres;
  logic [31:0]  rd;
  logic [103:0] pdt;
  logic [25:0]  dco, oen, pin, lit;
  logic [3:0]   mem [32];
  logic [31:0]  lf = 32'h36ec;
  int           n_errors = 0;
  int           checked = 0;
  always #50 clk_v = ~clk_v;
  lsd_decoder #(.PAIR_DC(PDC), .PAIR_OPEN(POD)) lsd_decoder_i (
    .CLK(clk_v), .NRST(nrst), .S_AXI_AWADDR(ad), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bres),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ad),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
    .S_AXI_RRESP(rres), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
    .PANEL_DRIVE_TERMINAL(pdt), .DC_OUT(dco), .DC_OE_N(oen));
  lsd_panel lsd_panel_i (.drive(pdt), .dc_out(dco), .dc_oe_n(oen), .pin(pin),
    .lit(lit));
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [155:0] expect_out(logic show);
    logic [155:0] e;
    for (int t = 0; t < 26; t++) begin
      e[t*4+:4] = PDC[t/2] ? 4'h0 : mem[t] & {4{show}};
      e[104+t] = PDC[t/2] & mem[t][0];
      e[130+t] = !PDC[t/2];
    end
    return e;
  endfunction
  task automatic chk(string nm, logic [155:0] seen, logic [155:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Ready is sampled at the falling edge so the handshake edge is known
  // before it arrives; each channel is released at the edge that took it,
  // and the response is left stalled one cycle on purpose.
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] e);
    logic ta, tw, ga, gw;
    ta = 1'b0;
    tw = 1'b0;
    ad <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk_v);
      ga = !ta && awr;
      gw = !tw && wrd;
      @(posedge clk_v);
      if (ga) begin
        awv <= 1'b0;
        ta = 1'b1;
      end
      if (gw) begin
        wv <= 1'b0;
        tw = 1'b1;
      end
    end
    while (!bv) @(negedge clk_v);
    chk("bresp", bres, e);
    @(posedge clk_v) br <= 1'b1;
    @(posedge clk_v) br <= 1'b0;
  endtask
  task automatic rdk(string nm, logic [11:0] a, logic [31:0] x,
                     logic [1:0] e);
    logic h;
    h = 1'b0;
    ad <= a;
    arv <= 1'b1;
    while (!h) begin
      @(negedge clk_v) h = arr;
      @(posedge clk_v);
    end
    arv <= 1'b0;
    while (!rv) @(negedge clk_v);
    chk(nm, rd, x);
    chk("rresp", rres, e);
    @(posedge clk_v) rr <= 1'b1;
    @(posedge clk_v) rr <= 1'b0;
  endtask
  initial begin
    logic         s;
    logic [155:0] e;
    logic [25:0]  le;
    repeat (8) @(posedge clk_v);
    nrst <= 1'b1;
    @(posedge clk_v);
    rdk("ctrl", `LSD_OFF_CTRL, 32'h1, `LSD_RESP_OKAY);
    rdk("pair_dc", `LSD_OFF_MODE, {19'h0, PDC}, `LSD_RESP_OKAY);
    rdk("pair_od", `LSD_OFF_OPEN, {19'h0, POD}, `LSD_RESP_OKAY);
    wr(12'h200, 32'hffff, `LSD_RESP_SLVERR);
    rdk("unmapped", 12'h200, 32'h0, `LSD_RESP_SLVERR);
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 32; k++) begin
        lf = nx(lf);
        mem[k] = (r == 2) ? 4'hf : lf[3:0];
        wr(12'(k * 4), {lf[31:4], mem[k]}, `LSD_RESP_OKAY);
      end
      s = (r != 1);
      wr(`LSD_OFF_CTRL, {31'h0, s}, `LSD_RESP_OKAY);
      repeat (110) @(posedge clk_v);
      @(negedge clk_v);
      e = expect_out(s);
      chk("outputs", {oen, dco, pdt}, e);
      chk("pins", pin, e[129:104]);
      for (int t = 0; t < 26; t++) begin
        le[t] = |e[t*4+:4];
      end
      chk("lit", lit, le);
      @(posedge clk_v);
      rdk("dc_level", `LSD_OFF_DCLEVEL, {6'h0, e[129:104]},
          `LSD_RESP_OKAY);
      for (int k = 0; k < 32; k++) begin
        rdk("mem", 12'(k * 4), {28'h0, mem[k]}, `LSD_RESP_OKAY);
      end
    end
    end_of_test;
  end
  initial begin
    #2000000;
    n_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
